/* alrc_top.sv */
// Added by the designer: the address map and the APB register port.
`timescale 1ns/1ps
`include "alrc_defines.svh"

module alrc_top
    import alrc_pkg::*;
(
    input wire logic CLK_SYS_I,
    input wire logic RESETN_I,
    input wire alrc_apb_req_t APB_REQ_I,
    input wire logic [`ALRC_NUM_INPUTS*`ALRC_RD_W-1:0] READING_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    output logic RELAY_HI_O,
    output logic RELAY_LO_O,
    output logic BEEP_O,
    output logic IRQ_O
);

    localparam int NI = `ALRC_NUM_INPUTS;
    localparam int RW = `ALRC_RD_W;
    // Input configuration reset word; each field is sliced out of it below.
    localparam logic [11:0] INCFG_RST = `ALRC_RST_INCFG;

    // ==========================================================
    // Declarations
    logic rst_meta_reg;
    logic rst_sync_reg;
    logic rst_n;

    logic access;
    logic wr_now;
    logic rd_now;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic mapped;
    logic [31:0] rd_mux;

    logic beep_en_reg;
    alrc_relay_cfg_t hi_cfg_reg;
    alrc_relay_cfg_t lo_cfg_reg;
    logic [NI-1:0] in_en_reg;
    logic [NI-1:0] in_latch_reg;
    logic [NI-1:0] in_steer_reg;
    logic [RW-1:0] hi_thr_reg [NI];
    logic [RW-1:0] lo_thr_reg [NI];
    logic alarm_reset_reg;

    logic [NI-1:0] hi_act;
    logic [NI-1:0] lo_act;
    logic [NI-1:0] hi_act_d_reg;
    logic [NI-1:0] lo_act_d_reg;
    logic hi_any;
    logic lo_any;
    logic relay_hi;
    logic relay_lo;

    logic [2*NI-1:0] irq_event;
    logic [2*NI-1:0] irq_stat_reg;
    logic [2*NI-1:0] irq_en_reg;
    logic [2*NI-1:0] irq_clr;

    // ==========================================================
    // Reset release
    // The asynchronous reset is let go only through two flops, so every
    // register leaves reset on the same clean edge.
    always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    assign rst_n = rst_sync_reg;

    // ==========================================================
    // APB decode
    // Every access takes one wait state: PREADY rises in the second access
    // cycle, and writes land only on the edge where it is sampled high.
    assign access = APB_REQ_I.psel && APB_REQ_I.penable;
    assign wr_now = access && PREADY_O && APB_REQ_I.pwrite;
    assign rd_now = access && !PREADY_O && !APB_REQ_I.pwrite;
    assign addr = APB_REQ_I.paddr;
    assign wdata = APB_REQ_I.pwdata;

    // Address map and read data selection.
    always_comb begin
        mapped = 1'b1;
        rd_mux = 32'h0000_0000;
        case (addr)
            `ALRC_OFS_CTRL: begin
                rd_mux[`ALRC_CTRL_BEEP_BIT] = beep_en_reg;
                rd_mux[`ALRC_CTRL_HMODE_LSB +: 2] = hi_cfg_reg.mode;
                rd_mux[`ALRC_CTRL_LMODE_LSB +: 2] = lo_cfg_reg.mode;
                rd_mux[`ALRC_CTRL_HMAN_BIT] = hi_cfg_reg.manual_on;
                rd_mux[`ALRC_CTRL_LMAN_BIT] = lo_cfg_reg.manual_on;
            end
            `ALRC_OFS_INCFG: begin
                rd_mux[`ALRC_INCFG_EN_LSB +: NI] = in_en_reg;
                rd_mux[`ALRC_INCFG_LATCH_LSB +: NI] = in_latch_reg;
                rd_mux[`ALRC_INCFG_STEER_LSB +: NI] = in_steer_reg;
            end
            `ALRC_OFS_ARST: begin
                rd_mux = 32'h0000_0000;
            end
            `ALRC_OFS_STATUS: begin
                rd_mux[`ALRC_ST_HREL_BIT] = RELAY_HI_O;
                rd_mux[`ALRC_ST_LREL_BIT] = RELAY_LO_O;
                rd_mux[`ALRC_ST_BEEP_BIT] = BEEP_O;
                rd_mux[`ALRC_ST_HACT_LSB +: NI] = hi_act;
                rd_mux[`ALRC_ST_LACT_LSB +: NI] = lo_act;
            end
            `ALRC_OFS_IRQ_STAT: begin
                rd_mux[2*NI-1:0] = irq_stat_reg;
            end
            `ALRC_OFS_IRQ_EN: begin
                rd_mux[2*NI-1:0] = irq_en_reg;
            end
            `ALRC_OFS_IRQ_CLR: begin
                rd_mux = 32'h0000_0000;
            end
            default: begin
                mapped = 1'b0;
                for (int k = 0; k < NI; k++) begin
                    if (addr == 8'(`ALRC_OFS_THR_BASE + 8 * k)) begin
                        mapped = 1'b1;
                        rd_mux[RW-1:0] = hi_thr_reg[k];
                    end
                    if (addr == 8'(`ALRC_OFS_THR_BASE + 8 * k + 4)) begin
                        mapped = 1'b1;
                        rd_mux[RW-1:0] = lo_thr_reg[k];
                    end
                end
            end
        endcase
    end

    // ==========================================================
    // APB answer
    // PREADY is a one-cycle pulse; read data is caught with it and held
    // until the next read so the bus sees a stable value.
    // A write to an unmapped address changes nothing; only the error flag
    // tells the master that it went astray.
    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            PREADY_O <= 1'b0;
            PSLVERR_O <= 1'b0;
            PRDATA_O <= 32'h0000_0000;
        end else begin
            PREADY_O <= access && !PREADY_O;
            PSLVERR_O <= access && !PREADY_O && !mapped;
            if (rd_now) begin
                PRDATA_O <= mapped ? rd_mux : 32'h0000_0000;
            end
        end
    end

    // ==========================================================
    // Control register: beeper enable and relay settings
    // The spare mode code is stored and read back as written, so software sees
    // what it wrote; the relay drivers treat it as off.
    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            beep_en_reg <= `ALRC_RST_BEEP_EN;
            hi_cfg_reg <= '{mode: ALRC_MODE_OFF, manual_on: 1'b0};
            lo_cfg_reg <= '{mode: ALRC_MODE_OFF, manual_on: 1'b0};
        end else if (wr_now && addr == `ALRC_OFS_CTRL) begin
            beep_en_reg <= wdata[`ALRC_CTRL_BEEP_BIT];
            hi_cfg_reg.mode <= alrc_mode_t'(wdata[`ALRC_CTRL_HMODE_LSB +: 2]);
            lo_cfg_reg.mode <= alrc_mode_t'(wdata[`ALRC_CTRL_LMODE_LSB +: 2]);
            hi_cfg_reg.manual_on <= wdata[`ALRC_CTRL_HMAN_BIT];
            lo_cfg_reg.manual_on <= wdata[`ALRC_CTRL_LMAN_BIT];
        end
    end

    // ==========================================================
    // Input configuration: alarm enable, latch and steering per input
    // Clearing an enable bit drops both alarms of that input at the next edge,
    // even a latched one, so no alarm reset is needed afterwards.
    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            in_en_reg <= INCFG_RST[`ALRC_INCFG_EN_LSB +: NI];
            in_latch_reg <= INCFG_RST[`ALRC_INCFG_LATCH_LSB +: NI];
            in_steer_reg <= INCFG_RST[`ALRC_INCFG_STEER_LSB +: NI];
        end else if (wr_now && addr == `ALRC_OFS_INCFG) begin
            in_en_reg <= wdata[`ALRC_INCFG_EN_LSB +: NI];
            in_latch_reg <= wdata[`ALRC_INCFG_LATCH_LSB +: NI];
            in_steer_reg <= wdata[`ALRC_INCFG_STEER_LSB +: NI];
        end
    end

    // ==========================================================
    // Alarm-reset command
    // A write of 1 to bit 0 makes one pulse that every input sees together.
    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            alarm_reset_reg <= 1'b0;
        end else begin
            alarm_reset_reg <= wr_now && addr == `ALRC_OFS_ARST && wdata[0];
        end
    end

    // ==========================================================
    // Per-input thresholds and alarm evaluation
    genvar gi;
    generate
        for (gi = 0; gi < NI; gi++) begin : g_in
            alrc_in_cfg_t cfg;

            assign cfg = '{enable: in_en_reg[gi], latch: in_latch_reg[gi],
                           steer: in_steer_reg[gi]};

            // Thresholds are plain settings; changing one takes effect on the
            // next compare, which may raise or drop an alarm at once.
            always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
                if (!rst_n) begin
                    hi_thr_reg[gi] <= `ALRC_RST_HI_THR;
                    lo_thr_reg[gi] <= `ALRC_RST_LO_THR;
                end else if (wr_now) begin
                    if (addr == 8'(`ALRC_OFS_THR_BASE + 8 * gi)) begin
                        hi_thr_reg[gi] <= wdata[RW-1:0];
                    end
                    if (addr == 8'(`ALRC_OFS_THR_BASE + 8 * gi + 4)) begin
                        lo_thr_reg[gi] <= wdata[RW-1:0];
                    end
                end
            end

            alrc_input_alarm u_alarm (
                .clk_i(CLK_SYS_I),
                .rst_n_i(rst_n),
                .reading_i(READING_I[gi*RW +: RW]),
                .hi_thr_i(hi_thr_reg[gi]),
                .lo_thr_i(lo_thr_reg[gi]),
                .cfg_i(cfg),
                .alarm_reset_i(alarm_reset_reg),
                .hi_act_o(hi_act[gi]),
                .lo_act_o(lo_act[gi])
            );
        end
    endgenerate

    // ==========================================================
    // Relay steering
    // Only steered inputs count; any one active alarm is enough.
    assign hi_any = |(hi_act & in_steer_reg);
    assign lo_any = |(lo_act & in_steer_reg);

    alrc_relay_drv u_relay_hi (
        .clk_i(CLK_SYS_I),
        .rst_n_i(rst_n),
        .cfg_i(hi_cfg_reg),
        .alarm_any_i(hi_any),
        .relay_o(relay_hi)
    );

    alrc_relay_drv u_relay_lo (
        .clk_i(CLK_SYS_I),
        .rst_n_i(rst_n),
        .cfg_i(lo_cfg_reg),
        .alarm_any_i(lo_any),
        .relay_o(relay_lo)
    );

    // ==========================================================
    // Relay and beeper outputs
    // Relay outputs come from the drivers' coil flops; the beeper ignores
    // steering, since it covers every enabled alarm.
    assign RELAY_HI_O = relay_hi;
    assign RELAY_LO_O = relay_lo;

    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            BEEP_O <= 1'b0;
        end else begin
            BEEP_O <= beep_en_reg && |(hi_act | lo_act);
        end
    end

    // ==========================================================
    // Interrupt events: onset of each high and low alarm
    // The delayed copies reset to the idle level of the alarms, so the release
    // of reset never looks like an onset.
    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            hi_act_d_reg <= NI'(0);
            lo_act_d_reg <= NI'(0);
        end else begin
            hi_act_d_reg <= hi_act;
            lo_act_d_reg <= lo_act;
        end
    end

    assign irq_event = {lo_act & ~lo_act_d_reg, hi_act & ~hi_act_d_reg};
    assign irq_clr = (wr_now && addr == `ALRC_OFS_IRQ_CLR) ? wdata[2*NI-1:0]
                                                              : (2*NI)'(0);

    // Sticky status; an event in the clearing cycle wins over the clear.
    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            irq_stat_reg <= (2*NI)'(0);
        end else begin
            irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_event;
        end
    end

    // Interrupt mask, laid out like the sticky status.
    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            irq_en_reg <= (2*NI)'(0);
        end else if (wr_now && addr == `ALRC_OFS_IRQ_EN) begin
            irq_en_reg <= wdata[2*NI-1:0];
        end
    end

    // Level interrupt, registered so it is glitch free at the pin.
    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            IRQ_O <= 1'b0;
        end else begin
            IRQ_O <= |(((irq_stat_reg & ~irq_clr) | irq_event) & irq_en_reg);
        end
    end

endmodule

/* alrc_defines.svh */
`ifndef ALRC_DEFINES_SVH
`define ALRC_DEFINES_SVH

// ==========================================================
// Geometry
`define ALRC_NUM_INPUTS 4
`define ALRC_RD_W 16

// ==========================================================
// Register byte offsets
`define ALRC_OFS_CTRL 8'h00
`define ALRC_OFS_INCFG 8'h04
`define ALRC_OFS_ARST 8'h08
`define ALRC_OFS_STATUS 8'h0c
`define ALRC_OFS_IRQ_STAT 8'h10
`define ALRC_OFS_IRQ_EN 8'h14
`define ALRC_OFS_IRQ_CLR 8'h18
`define ALRC_OFS_THR_BASE 8'h20

// ==========================================================
// Control register fields
`define ALRC_CTRL_BEEP_BIT 0
`define ALRC_CTRL_HMODE_LSB 1
`define ALRC_CTRL_LMODE_LSB 3
`define ALRC_CTRL_HMAN_BIT 5
`define ALRC_CTRL_LMAN_BIT 6

// ==========================================================
// Input configuration fields, one bit per input
`define ALRC_INCFG_EN_LSB 0
`define ALRC_INCFG_LATCH_LSB 4
`define ALRC_INCFG_STEER_LSB 8

// ==========================================================
// Status register fields
`define ALRC_ST_HREL_BIT 0
`define ALRC_ST_LREL_BIT 1
`define ALRC_ST_BEEP_BIT 2
`define ALRC_ST_HACT_LSB 4
`define ALRC_ST_LACT_LSB 8

// ==========================================================
// Reset values
`define ALRC_RST_BEEP_EN 1'b1
`define ALRC_RST_HI_THR 16'h03e8
`define ALRC_RST_LO_THR 16'h0000
`define ALRC_RST_INCFG 12'h000

`endif

/* alrc_pkg.sv */
package alrc_pkg;

    // Relay operating mode.
    typedef enum logic [1:0] {
        ALRC_MODE_OFF = 2'h0,
        ALRC_MODE_MANUAL = 2'h1,
        ALRC_MODE_ALARM = 2'h2
    } alrc_mode_t;

    // Settings of one relay.
    typedef struct packed {
        alrc_mode_t mode;
        logic manual_on;
    } alrc_relay_cfg_t;

    // APB request from the master.
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } alrc_apb_req_t;

    // Per-input alarm options.
    typedef struct packed {
        logic enable;
        logic latch;
        logic steer;
    } alrc_in_cfg_t;

endpackage

/* alrc_input_alarm.sv */
`timescale 1ns/1ps
`include "alrc_defines.svh"

// Alarm evaluation for one sensor input: compares the reading with both
// thresholds and keeps the high and low alarm states, latched or not.
module alrc_input_alarm
    import alrc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic signed [`ALRC_RD_W-1:0] reading_i,
    input wire logic signed [`ALRC_RD_W-1:0] hi_thr_i,
    input wire logic signed [`ALRC_RD_W-1:0] lo_thr_i,
    input wire alrc_in_cfg_t cfg_i,
    input wire logic alarm_reset_i,
    output logic hi_act_o,
    output logic lo_act_o
);

    logic hi_cond;
    logic lo_cond;
    logic hi_act_next;
    logic lo_act_next;

    // ==========================================================
    // Conditions
    // Strict comparisons: a reading equal to a threshold raises nothing.
    assign hi_cond = cfg_i.enable && (reading_i > hi_thr_i);
    assign lo_cond = cfg_i.enable && (reading_i < lo_thr_i);

    // ==========================================================
    // Next state
    // A latched alarm holds until its input is disabled or a reset finds its condition gone; the reset
    // simply reloads the live condition, so a still-present one stays set.
    always_comb begin
        if (!cfg_i.enable) begin
            hi_act_next = 1'b0;
            lo_act_next = 1'b0;
        end else if (cfg_i.latch && !alarm_reset_i) begin
            hi_act_next = hi_act_o | hi_cond;
            lo_act_next = lo_act_o | lo_cond;
        end else begin
            hi_act_next = hi_cond;
            lo_act_next = lo_cond;
        end
    end

    // ==========================================================
    // State
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hi_act_o <= 1'b0;
            lo_act_o <= 1'b0;
        end else begin
            hi_act_o <= hi_act_next;
            lo_act_o <= lo_act_next;
        end
    end

endmodule

/* alrc_relay_drv.sv */
`timescale 1ns/1ps
`include "alrc_defines.svh"

// Drive of one relay coil; 0 is the normal position, 1 the opposite one.
module alrc_relay_drv
    import alrc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire alrc_relay_cfg_t cfg_i,
    input wire logic alarm_any_i,
    output logic relay_o
);

    logic relay_next;

    // ==========================================================
    // Mode selection
    // The unused fourth mode code is treated as off so the coil never floats.
    always_comb begin
        case (cfg_i.mode)
            ALRC_MODE_OFF: relay_next = 1'b0;
            ALRC_MODE_MANUAL: relay_next = cfg_i.manual_on;
            ALRC_MODE_ALARM: relay_next = alarm_any_i;
            default: relay_next = 1'b0;
        endcase
    end

    // ==========================================================
    // Coil register
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            relay_o <= 1'b0;
        end else begin
            relay_o <= relay_next;
        end
    end

endmodule

/* alrc_monitor.sv */
`timescale 1ns/1ps
`include "alrc_defines.svh"

// Port-level watcher of the alarm relay block; it shadows CTRL and IRQ_EN.
module alrc_monitor
    import alrc_pkg::*;
(
    input wire logic CLK_SYS_I,
    input wire logic RESETN_I,
    input wire alrc_apb_req_t APB_REQ_I,
    input wire logic [`ALRC_NUM_INPUTS*`ALRC_RD_W-1:0] READING_I,
    input wire logic [31:0] PRDATA_O,
    input wire logic PREADY_O,
    input wire logic PSLVERR_O,
    input wire logic RELAY_HI_O,
    input wire logic RELAY_LO_O,
    input wire logic BEEP_O,
    input wire logic IRQ_O
);
    default clocking @(posedge CLK_SYS_I); endclocking
    default disable iff (!RESETN_I);

    // ==========================================================
    // Shadow registers
    logic wr_done;
    logic [31:0] ctrl_shadow_reg;
    logic [31:0] irq_en_shadow_reg;
    logic [1:0] cfg_age_reg;

    // A write counts only where the master samples an error-free answer.
    assign wr_done = APB_REQ_I.psel && APB_REQ_I.penable && APB_REQ_I.pwrite
        && PREADY_O && !PSLVERR_O;

    // Copies of the settings that decide the outputs without any alarm.
    always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            ctrl_shadow_reg <= 32'h0000_0001;
            irq_en_shadow_reg <= 32'h0000_0000;
        end else if (wr_done && APB_REQ_I.paddr == `ALRC_OFS_CTRL) begin
            ctrl_shadow_reg <= APB_REQ_I.pwdata;
        end else if (wr_done && APB_REQ_I.paddr == `ALRC_OFS_IRQ_EN) begin
            irq_en_shadow_reg <= APB_REQ_I.pwdata;
        end
    end

    // Age since the last write; outputs are judged against the shadows only once it settles.
    always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            cfg_age_reg <= 2'h0;
        end else if (wr_done) begin
            cfg_age_reg <= 2'h0;
        end else if (cfg_age_reg != 2'h3) begin
            cfg_age_reg <= cfg_age_reg + 2'h1;
        end
    end

    // ==========================================================
    // Bus answer
    property p_ready_wait;
        APB_REQ_I.psel && APB_REQ_I.penable && !PREADY_O |=> PREADY_O;
    endproperty
    a_ready_wait: assert property (p_ready_wait) else $error("late ready");

    property p_ready_pulse;
        PREADY_O |=> !PREADY_O;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready too long");

    property p_ready_access;
        PREADY_O |-> APB_REQ_I.psel && APB_REQ_I.penable;
    endproperty
    a_ready_access: assert property (p_ready_access) else $error("stray ready");

    property p_err_ready;
        PSLVERR_O |-> PREADY_O;
    endproperty
    a_err_ready: assert property (p_err_ready) else $error("error without ready");

    // ==========================================================
    // Outputs against settings
    property p_reset_quiet;
        $rose(RESETN_I) |-> (!RELAY_HI_O && !RELAY_LO_O && !IRQ_O) [*3];
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("output after reset");

    property p_hi_off;
        cfg_age_reg == 2'h3 && ctrl_shadow_reg[2:1] inside {2'h0, 2'h3} |-> !RELAY_HI_O;
    endproperty
    a_hi_off: assert property (p_hi_off) else $error("high relay moved when off");

    property p_hi_man;
        cfg_age_reg == 2'h3 && ctrl_shadow_reg[2:1] == 2'h1 |-> RELAY_HI_O == ctrl_shadow_reg[5];
    endproperty
    a_hi_man: assert property (p_hi_man) else $error("high relay manual");

    property p_lo_man;
        cfg_age_reg == 2'h3 && ctrl_shadow_reg[4:3] == 2'h1 |-> RELAY_LO_O == ctrl_shadow_reg[6];
    endproperty
    a_lo_man: assert property (p_lo_man) else $error("low relay manual");

    property p_beep_off;
        cfg_age_reg == 2'h3 && !ctrl_shadow_reg[0] |-> !BEEP_O;
    endproperty
    a_beep_off: assert property (p_beep_off) else $error("beeper while disabled");

    property p_irq_off;
        cfg_age_reg == 2'h3 && irq_en_shadow_reg[7:0] == 8'h00 |-> !IRQ_O;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("interrupt while masked");
endmodule

bind alrc_top alrc_monitor u_alrc_monitor (
    .CLK_SYS_I(CLK_SYS_I), .RESETN_I(RESETN_I), .APB_REQ_I(APB_REQ_I),
    .READING_I(READING_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O),
    .PSLVERR_O(PSLVERR_O), .RELAY_HI_O(RELAY_HI_O), .RELAY_LO_O(RELAY_LO_O),
    .BEEP_O(BEEP_O), .IRQ_O(IRQ_O)
);

/* alrc_relay_load.sv */
`timescale 1ns/1ps

// Two relays switching outside equipment; contacts follow coils a cycle late.
module alrc_relay_load (
    input wire logic clk_i,
    input wire logic coil_hi_i,
    input wire logic coil_lo_i,
    output logic load_hi_o,
    output logic load_lo_o
);
    // The armature lags the coil, so the load sees the change one cycle later.
    always_ff @(posedge clk_i) begin
        load_hi_o <= coil_hi_i;
        load_lo_o <= coil_lo_i;
    end
endmodule

/* alrc_top_test.sv */
`timescale 1ns/1ps
`include "alrc_defines.svh"

// Register-level bench of the alarm relay block.
module alrc_top_test
    import alrc_pkg::*;
;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    alrc_apb_req_t req = '0;
    logic [63:0] rd = 64'h0;
    logic [31:0] prdata, dat;
    logic pready, pslverr, relay_hi, relay_lo, beep, irq, load_hi, load_lo, err;
    int miscompares = 0;
    int samples_checked = 0;
    int cycles = 0;

    // ==========================================================
    // Clock, design and relay loads
    always #10 clk_sys = ~clk_sys;

    alrc_top u_alrc_top (
        .CLK_SYS_I(clk_sys), .RESETN_I(resetn), .APB_REQ_I(req), .READING_I(rd),
        .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
        .RELAY_HI_O(relay_hi), .RELAY_LO_O(relay_lo), .BEEP_O(beep), .IRQ_O(irq)
    );

    alrc_relay_load u_alrc_relay_load (
        .clk_i(clk_sys), .coil_hi_i(relay_hi), .coil_lo_i(relay_lo),
        .load_hi_o(load_hi), .load_lo_o(load_lo)
    );

    // ==========================================================
    // Tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    // The request is held until pready is seen high at a rising edge.
    task automatic apb(input logic wr_en, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk_sys);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr_en, paddr: a, pwdata: wd};
        @(posedge clk_sys);
        req.penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        dat = prdata;
        err = pslverr;
        req <= '0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        apb(1'b1, a, wd);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(dat, exp);
    endtask

    task automatic setr(input int i, input logic [15:0] v);
        @(posedge clk_sys);
        rd[16*i +: 16] <= v;
    endtask

    // Alarms reach the relays two edges after a reading; four leave margin.
    task automatic settle;
        repeat (4) @(posedge clk_sys);
    endtask

    task stop_test;
        $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // A hang is cut short well beyond the few hundred cycles the run needs.
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            $display("mismatch at %0t: timeout", $time);
            stop_test;
        end
    end

    // ==========================================================
    // Main sequence
    initial begin
        repeat (6) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rdc(`ALRC_OFS_CTRL, 32'h1);
        rdc(`ALRC_OFS_INCFG, 32'h0);
        rdc(`ALRC_OFS_THR_BASE, 32'h3e8);
        rdc(`ALRC_OFS_THR_BASE + 8'h04, 32'h0);
        rdc(8'h1c, 32'h0);
        chk(err, 32'h1);
        wr(`ALRC_OFS_STATUS, 32'hffff);
        rdc(`ALRC_OFS_STATUS, 32'h0);
        for (int m = 0; m < 4; m++) begin
            wr(`ALRC_OFS_CTRL, 32'h61 | (m << 1) | (m << 3));
            settle;
            chk(load_hi, m == 1);
            chk(relay_lo, m == 1);
        end
        wr(`ALRC_OFS_CTRL, 32'h2b);
        settle;
        chk(relay_lo, 32'h0);
        rdc(`ALRC_OFS_STATUS, 32'h1);
        // Only input 1 is steered; input 0 alarms but must not move a relay.
        wr(`ALRC_OFS_CTRL, 32'h15);
        wr(`ALRC_OFS_INCFG, 32'h203);
        setr(0, 16'h07d0);
        setr(1, 16'hfffb);
        settle;
        chk(relay_hi, 32'h0);
        chk(load_lo, 32'h1);
        chk(beep, 32'h1);
        rdc(`ALRC_OFS_STATUS, 32'h216);
        setr(0, 16'h03e8);
        settle;
        rdc(`ALRC_OFS_STATUS, 32'h206);
        wr(`ALRC_OFS_INCFG, 32'h303);
        setr(0, 16'h03e9);
        settle;
        chk(relay_hi, 32'h1);
        setr(0, 16'h01f4);
        setr(1, 16'h0000);
        settle;
        rdc(`ALRC_OFS_STATUS, 32'h0);
        // Latched alarms: one condition clears, the other persists.
        wr(`ALRC_OFS_INCFG, 32'h333);
        setr(0, 16'h07d0);
        setr(1, 16'hfffb);
        settle;
        setr(0, 16'h01f4);
        settle;
        rdc(`ALRC_OFS_STATUS, 32'h217);
        wr(`ALRC_OFS_ARST, 32'h1);
        settle;
        rdc(`ALRC_OFS_STATUS, 32'h206);
        wr(`ALRC_OFS_CTRL, 32'h14);
        settle;
        chk(beep, 32'h0);
        // Interrupt on a fresh high-alarm onset of input 0.
        wr(`ALRC_OFS_IRQ_CLR, 32'hff);
        rdc(`ALRC_OFS_IRQ_STAT, 32'h0);
        wr(`ALRC_OFS_IRQ_EN, 32'h1);
        setr(0, 16'h07d0);
        settle;
        chk(irq, 32'h1);
        rdc(`ALRC_OFS_IRQ_STAT, 32'h1);
        wr(`ALRC_OFS_IRQ_EN, 32'h0);
        settle;
        chk(irq, 32'h0);
        rdc(`ALRC_OFS_IRQ_STAT, 32'h1);
        wr(`ALRC_OFS_IRQ_EN, 32'h1);
        settle;
        chk(irq, 32'h1);
        wr(`ALRC_OFS_IRQ_CLR, 32'h1);
        settle;
        chk(irq, 32'h0);
        rdc(`ALRC_OFS_IRQ_CLR, 32'h0);
        stop_test;
    end
endmodule
